// ===== inc/slc_params.svh
// constants for the serial line codec: timing, flag pattern and stuffing counts
// Summary of operation
// - sync: change data on falling, sample rising
// - transmitting node drives the bit clock pair
// - sync bit rate 500 kbit/s to 2.4 Mbit/s
// - self-clocked rates 375 or 62.5 kbit/s
// - repeater direction pair only in self-clocked mode
// - responding slave reverses direction pair, else undriven
// - direction pair may be omitted without repeaters
// - pair is one when true line above complement
// - sync bit value is data level at rise
// - recognise and send flag 01111110
// - transmitter inserts zero after five ones
// - receiver deletes zero after five ones
// - NRZI zero toggles, one holds polarity
// - stuffing also applies in self-clocked mode
// - self-clocked frame preceded by eight zero preamble
// - DPLL at 16x bit rate, one-step adjustments
`ifndef SLC_PARAMS_SVH
`define SLC_PARAMS_SVH

`define CLK_HZ              100000000
`define SYNC_RATE_MIN_BPS   500000
`define SYNC_RATE_MAX_BPS   2400000
`define SELF_RATE_FAST_BPS  375000
`define SELF_RATE_SLOW_BPS  62500
`define DPLL_OVERSAMPLE     16
`define REF_INC(bps)        ((64'd16 * (bps) * 64'd65536) / `CLK_HZ)
`define SYNC_HALF_MIN       ((`CLK_HZ + 2 * `SYNC_RATE_MAX_BPS - 1) / (2 * `SYNC_RATE_MAX_BPS))
`define SYNC_HALF_MAX       (`CLK_HZ / (2 * `SYNC_RATE_MIN_BPS))
`define FLAG_PATTERN        8'h7E
`define PREAMBLE_ZEROS      4'h8
`define STUFF_RUN           3'h5
`define FLAG_RUN            3'h6
`define ABORT_RUN           3'h7
`define DPLL_LAST           4'hF
`define DPLL_SAMPLE         4'h8
`define BUF_DEPTH           2

`endif

// ===== inc/slc_pkg.sv
// types shared by the serial line codec and its receive buffer
`include "slc_params.svh"
package slc_pkg;

   typedef struct packed {
      logic       flag;    // entry marks a closing flag, data is zero
      logic [7:0] data;
   } slc_word_t;

   typedef struct packed {
      logic       last;    // final byte of the frame
      logic [7:0] data;
   } slc_tx_word_t;

   typedef struct packed {
      logic p;             // true line
      logic n;             // complement line
   } slc_pair_in_t;

   typedef struct packed {
      logic p;
      logic n;
      logic oe;            // high while driven
   } slc_pair_out_t;

   typedef struct packed {
      logic       self_clocked;  // 0 synchronous, 1 self-clocked
      logic       rate_slow;     // self-clocked: 0 fast, 1 slow rate
      logic       is_slave;
      logic       dir_enable;    // repeaters present
      logic [7:0] half_div;      // sync: mclk cycles per half bit
   } slc_cfg_t;

   typedef enum logic [2:0] {
      SLC_IDLE,
      SLC_PRE,
      SLC_FLAG,
      SLC_DATA,
      SLC_FINISH
   } slc_tx_state_t;

   typedef struct packed {
      logic [2:0]    clk_s;
      logic [2:0]    dat_s;
      logic          clk_f;
      logic          dat_f;
      logic [15:0]   acc;
      slc_tx_state_t tst;
      logic [3:0]    tcnt;
      logic [2:0]    tones;
      logic [7:0]    tshift;
      logic          tlast;
      logic          tclose;
      slc_tx_word_t  hold;
      logic          hold_full;
      logic [7:0]    half_cnt;
      logic          bclk;
      logic          line;
      logic [3:0]    tref;
      logic [3:0]    dcnt;
      logic          edge_seen;
      logic          prev_samp;
      logic [2:0]    rones;
      logic [2:0]    rbits;
      logic [7:0]    rsh;
      logic          in_frame;
      logic          got_data;
      slc_word_t     rword;
      logic          push;
      logic          overrun;
   } slc_state_t;

   typedef struct packed {
      slc_word_t [`BUF_DEPTH-1:0] mem;
      logic                       wp;
      logic                       rp;
      logic [1:0]                 cnt;
   } slc_buf_state_t;

endpackage

// ===== rtl/slc_pair_buffer.sv
// two-entry buffer between the receive engine and its consumer
`timescale 1ns/10ps
`include "slc_params.svh"
module slc_pair_buffer
(
   input  wire logic             mclk,      // system clock
   input  wire logic             rst_n,     // async reset, active low
   input  wire logic             in_valid,  // word offered
   input  wire slc_pkg::slc_word_t in_word, // word in
   output logic                  in_ready,  // room for a word
   output logic                  out_valid, // word available
   output slc_pkg::slc_word_t    out_word,  // oldest word
   input  wire logic             out_ready  // consumer takes word
);

   slc_pkg::slc_buf_state_t s;
   slc_pkg::slc_buf_state_t next_s;
   logic                    wr;
   logic                    rd;

   assign in_ready  = (s.cnt != 2'(`BUF_DEPTH));
   assign out_valid = (s.cnt != 2'h0);
   assign out_word  = s.mem[s.rp];

   always_comb
   begin
      next_s = s;
      wr = in_valid && in_ready;
      rd = out_valid && out_ready;
      if (wr)
      begin
         next_s.mem[s.wp] = in_word;
         next_s.wp = ~s.wp;
      end
      if (rd)
         next_s.rp = ~s.rp;
      next_s.cnt = s.cnt + {1'b0, wr} - {1'b0, rd};
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end

endmodule // slc_pair_buffer

// ===== rtl/slc_line_codec.sv
// bit-level line codec: sync/self-clocked coding, flags, zero stuffing
`timescale 1ns/10ps
`include "slc_params.svh"
module slc_line_codec
(
   input  wire logic                  mclk,                // system clock, 100 MHz
   input  wire logic                  rst_n,               // async reset, active low
   input  wire slc_pkg::slc_cfg_t     cfg,                 // mode and rate settings
   input  wire logic                  tx_valid,            // byte offered for sending
   input  wire slc_pkg::slc_tx_word_t tx_word,             // byte and end-of-frame mark
   output logic                       tx_ready,            // holding register free, byte taken when valid
   output logic                       tx_busy,             // frame on the line
   output logic                       rx_valid,            // received entry available
   output slc_pkg::slc_word_t         rx_word,             // byte or closing flag
   input  wire logic                  rx_ready,            // consumer takes entry
   output logic                       rx_overrun,          // entry lost, one pulse
   input  wire slc_pkg::slc_pair_in_t data_pair_in,        // data pair receiver
   output slc_pkg::slc_pair_out_t     data_pair_out,       // data pair driver
   input  wire slc_pkg::slc_pair_in_t bit_clock_pair_in,   // bit clock pair receiver
   output slc_pkg::slc_pair_out_t     bit_clock_pair_out,  // bit clock pair driver
   output slc_pkg::slc_pair_out_t     dir_pair_out         // transceiver direction pair
);

   slc_pkg::slc_state_t s;
   slc_pkg::slc_state_t next_s;
   logic                buf_ready;
   logic                step;
   logic                emit;
   logic                b;
   logic                ref_tick;
   logic                clk_rise;
   logic                dat_edge;
   logic                bit_valid;
   logic                rb;
   logic [7:0]          half;
   logic [15:0]         inc;
   logic [7:0]          nbyte;

   // one when the true line sits above the complement
   function automatic logic pair_level(input slc_pkg::slc_pair_in_t pin);
      pair_level = pin.p & ~pin.n;
   endfunction

   // out-of-range settings are pulled into the legal sync rate band
   function automatic logic [7:0] clamp_half(input logic [7:0] d);
      if (d < 8'(`SYNC_HALF_MIN))
         clamp_half = 8'(`SYNC_HALF_MIN);
      else if (d > 8'(`SYNC_HALF_MAX))
         clamp_half = 8'(`SYNC_HALF_MAX);
      else
         clamp_half = d;
   endfunction

   assign tx_ready = !s.hold_full;
   assign tx_busy  = (s.tst != slc_pkg::SLC_IDLE);

   assign data_pair_out.p  = s.line;
   assign data_pair_out.n  = ~s.line;
   assign data_pair_out.oe = tx_busy;
   // only the transmitting node drives the clock pair
   assign bit_clock_pair_out.p  = s.bclk;
   assign bit_clock_pair_out.n  = ~s.bclk;
   assign bit_clock_pair_out.oe = tx_busy && !cfg.self_clocked;
   // reversed polarity steers repeaters toward the master; bias does the rest
   assign dir_pair_out.p  = 1'b0;
   assign dir_pair_out.n  = 1'b1;
   assign dir_pair_out.oe = tx_busy && cfg.self_clocked && cfg.is_slave
                            && cfg.dir_enable;

   assign rx_overrun = s.overrun;

   slc_pair_buffer u_rx_buf
   (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .in_valid  (s.push),
      .in_word   (s.rword),
      .in_ready  (buf_ready),
      .out_valid (rx_valid),
      .out_word  (rx_word),
      .out_ready (rx_ready)
   );

   always_comb
   begin
      next_s = s;
      step = 1'b0;
      emit = 1'b0;
      b = 1'b0;
      bit_valid = 1'b0;
      rb = 1'b0;
      nbyte = 8'h00;
      half = clamp_half(cfg.half_div);
      inc = cfg.rate_slow ? 16'(`REF_INC(`SELF_RATE_SLOW_BPS))
                          : 16'(`REF_INC(`SELF_RATE_FAST_BPS));

      // pins: three stages, a change counts once stages two and three agree
      next_s.clk_s = {s.clk_s[1:0], pair_level(bit_clock_pair_in)};
      next_s.dat_s = {s.dat_s[1:0], pair_level(data_pair_in)};
      if (s.clk_s[1] == s.clk_s[2])
         next_s.clk_f = s.clk_s[2];
      if (s.dat_s[1] == s.dat_s[2])
         next_s.dat_f = s.dat_s[2];
      clk_rise = (s.clk_s[1] == s.clk_s[2]) && s.clk_s[2] && !s.clk_f;
      dat_edge = (s.dat_s[1] == s.dat_s[2]) && (s.dat_s[2] != s.dat_f);

      // fractional divider gives the 16x reference tick
      {ref_tick, next_s.acc} = {1'b0, s.acc} + {1'b0, inc};

      // transmit bit timing
      if (s.tst != slc_pkg::SLC_IDLE)
      begin
         if (!cfg.self_clocked)
         begin
            if (s.half_cnt == half - 8'h01)
            begin
               next_s.half_cnt = 8'h00;
               next_s.bclk = ~s.bclk;
               step = s.bclk;
            end
            else
               next_s.half_cnt = s.half_cnt + 8'h01;
         end
         else if (ref_tick)
         begin
            next_s.tref = s.tref + 4'h1;
            step = (s.tref == `DPLL_LAST);
         end
      end
      else if (s.hold_full)
      begin
         // clock starts low so the first bit settles before the first rise
         step = 1'b1;
         next_s.half_cnt = 8'h00;
         next_s.bclk = 1'b0;
         next_s.tref = 4'h0;
      end

      if (step)
      begin
         emit = 1'b1;
         unique case (s.tst)
            slc_pkg::SLC_IDLE:
            begin
               next_s.tcnt = 4'h1;
               next_s.tclose = 1'b0;
               next_s.tones = 3'h0;
               next_s.tst = cfg.self_clocked ? slc_pkg::SLC_PRE : slc_pkg::SLC_FLAG;
            end
            slc_pkg::SLC_PRE:
            begin
               if (s.tcnt == `PREAMBLE_ZEROS)
               begin
                  next_s.tst = slc_pkg::SLC_FLAG;
                  next_s.tcnt = 4'h1;
               end
               else
                  next_s.tcnt = s.tcnt + 4'h1;
            end
            slc_pkg::SLC_FLAG:
            begin
               if (s.tcnt == 4'h0 && s.tones == `STUFF_RUN)
                  next_s.tones = 3'h0;
               else
               begin
                  b = 1'(`FLAG_PATTERN >> s.tcnt[2:0]);
                  next_s.tones = 3'h0;
                  if (s.tcnt == 4'h7)
                  begin
                     if (s.tclose)
                        next_s.tst = slc_pkg::SLC_FINISH;
                     else
                     begin
                        next_s.tst = slc_pkg::SLC_DATA;
                        next_s.tshift = s.hold.data;
                        next_s.tlast = s.hold.last;
                        next_s.hold_full = 1'b0;
                        next_s.tcnt = 4'h0;
                     end
                  end
                  else
                     next_s.tcnt = s.tcnt + 4'h1;
               end
            end
            slc_pkg::SLC_DATA:
            begin
               if (s.tones == `STUFF_RUN)
                  next_s.tones = 3'h0;
               else
               begin
                  b = s.tshift[0];
                  next_s.tshift = {1'b0, s.tshift[7:1]};
                  next_s.tones = b ? s.tones + 3'h1 : 3'h0;
                  if (s.tcnt == 4'h7)
                  begin
                     next_s.tcnt = 4'h0;
                     // an empty holding register ends the frame early
                     if (s.hold_full && !s.tlast)
                     begin
                        next_s.tshift = s.hold.data;
                        next_s.tlast = s.hold.last;
                        next_s.hold_full = 1'b0;
                     end
                     else
                     begin
                        next_s.tst = slc_pkg::SLC_FLAG;
                        next_s.tclose = 1'b1;
                     end
                  end
                  else
                     next_s.tcnt = s.tcnt + 4'h1;
               end
            end
            slc_pkg::SLC_FINISH:
            begin
               emit = 1'b0;
               next_s.tst = slc_pkg::SLC_IDLE;
            end
         endcase
      end

      if (emit)
         next_s.line = cfg.self_clocked ? (b ? s.line : ~s.line) : b;

      if (tx_valid && !s.hold_full)
      begin
         next_s.hold = tx_word;
         next_s.hold_full = 1'b1;
      end

      // receive bit recovery
      if (!cfg.self_clocked)
      begin
         bit_valid = clk_rise;
         rb = s.dat_f;
      end
      else
      begin
         if (ref_tick)
         begin
            next_s.edge_seen = 1'b0;
            // late edges hold the count back, early ones push it on
            if (s.edge_seen && s.dcnt != 4'h0 && s.dcnt < `DPLL_SAMPLE)
               next_s.dcnt = s.dcnt;
            else if (s.edge_seen && s.dcnt >= `DPLL_SAMPLE)
               next_s.dcnt = s.dcnt + 4'h2;
            else
               next_s.dcnt = s.dcnt + 4'h1;
            if (s.dcnt == `DPLL_SAMPLE)
            begin
               bit_valid = 1'b1;
               rb = (s.dat_f == s.prev_samp);
               next_s.prev_samp = s.dat_f;
            end
         end
         if (dat_edge)
            next_s.edge_seen = 1'b1;
      end

      next_s.push = 1'b0;
      if (bit_valid)
      begin
         if (!rb && s.rones == `FLAG_RUN)
         begin
            // closing flag reported only after a frame carried bytes
            if (s.in_frame && s.got_data)
            begin
               next_s.rword = '{flag: 1'b1, data: 8'h00};
               next_s.push = 1'b1;
            end
            next_s.in_frame = 1'b1;
            next_s.got_data = 1'b0;
            next_s.rbits = 3'h0;
            next_s.rones = 3'h0;
         end
         else if (!rb && s.rones == `STUFF_RUN)
            next_s.rones = 3'h0;
         else if (rb && s.rones >= `FLAG_RUN)
         begin
            next_s.rones = `ABORT_RUN;
            next_s.in_frame = 1'b0;
         end
         else
         begin
            next_s.rones = rb ? s.rones + 3'h1 : 3'h0;
            if (s.in_frame)
            begin
               nbyte = {rb, s.rsh[7:1]};
               next_s.rsh = nbyte;
               next_s.rbits = s.rbits + 3'h1;
               if (s.rbits == 3'h7)
               begin
                  next_s.rword = '{flag: 1'b0, data: nbyte};
                  next_s.push = 1'b1;
                  next_s.got_data = 1'b1;
               end
            end
         end
      end
      // the line cannot be stalled, so a full buffer costs the entry
      next_s.overrun = s.push && !buf_ready;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end

endmodule // slc_line_codec

// ===== bench/slc_line_codec_assertions.sv
// concurrent checks on the line codec's ports
`timescale 1ns/10ps
module slc_line_codec_assertions
(
   input wire logic                   mclk,               // system clock
   input wire logic                   rst_n,              // async reset, active low
   input wire slc_pkg::slc_cfg_t      cfg,                // mode settings
   input wire logic                   tx_valid,           // byte offered
   input wire logic                   tx_ready,           // holding register free
   input wire logic                   tx_busy,            // frame on the line
   input wire logic                   rx_valid,           // entry available
   input wire slc_pkg::slc_word_t     rx_word,            // entry
   input wire logic                   rx_ready,           // consumer takes entry
   input wire logic                   rx_overrun,         // entry lost
   input wire slc_pkg::slc_pair_out_t data_pair_out,      // data pair driver
   input wire slc_pkg::slc_pair_out_t bit_clock_pair_out, // bit clock driver
   input wire slc_pkg::slc_pair_out_t dir_pair_out        // direction pair
);
   logic       bclk_q;
   logic [3:0] run;
   logic [3:0] next_run;

   // ones seen by a far receiver at each bit clock rise
   always_comb
   begin
      next_run = run;
      if (!bit_clock_pair_out.oe)
         next_run = 4'h0;
      else if (bit_clock_pair_out.p && !bclk_q)
         next_run = data_pair_out.p ? run + 4'h1 : 4'h0;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         run    <= 4'h0;
         bclk_q <= 1'b0;
      end
      else
      begin
         run    <= next_run;
         bclk_q <= bit_clock_pair_out.p;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   chk_ones_run: assert property (run <= 4'h6)
      else $error("more than six ones on the line");
   chk_data_edge: assert property (data_pair_out.oe && $past(data_pair_out.oe) &&
      !cfg.self_clocked && $changed(data_pair_out.p) |-> $fell(bit_clock_pair_out.p))
      else $error("data changed away from clock fall");
   chk_clk_driver: assert property (tx_busy && !cfg.self_clocked |-> bit_clock_pair_out.oe)
      else $error("sender not driving bit clock");
   chk_self_noclk: assert property (cfg.self_clocked |-> !bit_clock_pair_out.oe)
      else $error("bit clock driven in self-clocked mode");
   chk_dir_gate: assert property (dir_pair_out.oe |-> cfg.self_clocked &&
      cfg.is_slave && cfg.dir_enable && tx_busy)
      else $error("direction pair driven out of place");
   chk_dir_level: assert property (dir_pair_out.oe |-> !dir_pair_out.p && dir_pair_out.n)
      else $error("direction pair not reversed");
   chk_data_compl: assert property (data_pair_out.n == !data_pair_out.p)
      else $error("data pair lines not complementary");
   chk_clk_compl: assert property (bit_clock_pair_out.n == !bit_clock_pair_out.p)
      else $error("clock pair lines not complementary");
   chk_take_ready: assert property (tx_valid && tx_ready |=> !tx_ready)
      else $error("ready stayed high after a take");
   chk_busy_start: assert property (tx_valid && tx_ready && !tx_busy |=> ##1 tx_busy)
      else $error("busy did not follow the first take");
   chk_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
      else $error("entry changed before it was taken");

   cover property (tx_valid && tx_ready);
   cover property (rx_overrun);
   cover property (rx_valid && rx_word.flag);
   cover property (dir_pair_out.oe);
endmodule // slc_line_codec_assertions

// ===== bench/slc_far_node.sv
// far bus node: sync-mode frame sender and capture of the codec's bits
`timescale 1ns/10ps
module slc_far_node
(
   input  wire logic                   go,        // start a frame
   input  wire logic [15:0]            frame,     // {second, first} byte
   output logic                        busy,      // frame on the line
   output slc_pkg::slc_pair_in_t       data_pair, // data pair toward codec
   output slc_pkg::slc_pair_in_t       clk_pair,  // bit clock toward codec
   input  wire slc_pkg::slc_pair_out_t dut_data,  // codec data pair
   input  wire slc_pkg::slc_pair_out_t dut_clk,   // codec bit clock
   input  wire logic                   clr        // empty the capture
);
   logic [63:0] raw;
   int          nraw;
   int          ones;

   task automatic put(input logic b);
      begin
         data_pair = '{b, !b};             // change on the falling edge
         #62.5 clk_pair = '{1'b1, 1'b0};   // receiver samples here
         #62.5 clk_pair = '{1'b0, 1'b1};
      end
   endtask

   task automatic put_byte(input logic [7:0] v, input logic stuff);
      begin
         for (int i = 0; i < 8; i++)
         begin
            put(v[i]);
            ones = v[i] ? ones + 1 : 0;
            if (stuff && ones == 5)
            begin
               put(1'b0);
               ones = 0;
            end
         end
      end
   endtask

   initial
   begin
      busy      = 1'b0;
      data_pair = '{1'b0, 1'b1};
      clk_pair  = '{1'b0, 1'b1};
   end

   // clock stands low between frames, data shows the inverse of its last bit
   always @(posedge go)
   begin
      busy = 1'b1;
      put_byte(8'h7E, 1'b0);
      ones = 0;
      put_byte(frame[7:0], 1'b1);
      put_byte(frame[15:8], 1'b1);
      put_byte(8'h7E, 1'b0);
      data_pair = '{!data_pair.p, data_pair.p};
      busy = 1'b0;
   end

   always @(posedge dut_clk.p or posedge clr)
   begin
      if (clr)
      begin
         raw  = '0;
         nraw = 0;
      end
      else if (dut_clk.oe)
      begin
         raw  = {raw[62:0], dut_data.p};   // sampled on the rise
         nraw = nraw + 1;
      end
   end
endmodule // slc_far_node

// ===== bench/slc_line_codec_test.sv
// bench for the line codec: far frames in, codec frames out, stalled buffer
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
   $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module slc_line_codec_test;
   logic                   mclk, rst_n, tx_valid, tx_ready, tx_busy;
   logic                   rx_valid, rx_ready, rx_overrun, go, far_busy, clr, bq, dq, dir_seen;
   logic                   ovr_seen;
   slc_pkg::slc_cfg_t      cfg;
   slc_pkg::slc_tx_word_t  tx_word;
   slc_pkg::slc_word_t     rx_word;
   slc_pkg::slc_pair_in_t  data_pair_in, bit_clock_pair_in, far_data;
   slc_pkg::slc_pair_out_t data_pair_out, bit_clock_pair_out, dir_pair_out;
   slc_pkg::slc_word_t     got[$];
   logic [15:0]            frame;
   logic [15:0]            rows[3] = '{16'h7EFF, 16'h003E, 16'h1FF8};
   logic [16:0]            stx[2] = '{{1'b1, 8'h00, 8'd20}, {1'b0, 8'hFF, 8'd13}};
   int                     hv[2] = '{21, 100};
   int                     n_mismatch, cmp_count, cycles, per, pcnt, toggles;

   slc_line_codec i_dut (.mclk, .rst_n, .cfg, .tx_valid, .tx_word, .tx_ready, .tx_busy,
      .rx_valid, .rx_word, .rx_ready, .rx_overrun, .data_pair_in, .data_pair_out,
      .bit_clock_pair_in, .bit_clock_pair_out, .dir_pair_out);
   slc_far_node i_far (.go, .frame, .busy(far_busy), .data_pair(far_data),
      .clk_pair(bit_clock_pair_in), .dut_data(data_pair_out), .dut_clk(bit_clock_pair_out),
      .clr);

   // self-clocked: the codec hears its own line, so its clock recovery is exercised
   assign data_pair_in = cfg.self_clocked ? {data_pair_out.p, data_pair_out.n} : far_data;

   always #5 mclk = !mclk;

   task end_sim;
      begin
         $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
         if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         n_mismatch++;
         end_sim();
      end
      if (rx_valid && rx_ready)
         got.push_back(rx_word);
      if (rx_overrun)
         ovr_seen = 1'b1;
      if (bit_clock_pair_out.p && !bq)
      begin
         per  = pcnt;
         pcnt = 1;
      end
      else
         pcnt++;
      bq = bit_clock_pair_out.p;
      if (data_pair_out.oe && data_pair_out.p != dq)
         toggles++;
      dq = data_pair_out.p;
      if (dir_pair_out.oe)
         dir_seen = 1'b1;
   end

   task step(input int n);
      begin
         repeat (n) @(posedge mclk);
         #1;
      end
   endtask

   // ready is register-driven, so seen high here it holds to the taking edge
   task send(input slc_pkg::slc_tx_word_t w);
      begin
         tx_valid = 1'b1;
         tx_word  = w;
         while (tx_ready !== 1'b1)
            step(1);
         step(1);
         tx_valid = 1'b0;
         // busy rises only one cycle after the take
         wait (tx_busy === 1'b1);
         wait (tx_busy === 1'b0);
         step(2);
      end
   endtask

   task far(input logic [15:0] f);
      begin
         frame = f;
         go    = 1'b1;
         step(1);
         go = 1'b0;
         wait (far_busy === 1'b0);
         step(50);
      end
   endtask

   initial
   begin
      {mclk, rst_n, tx_valid, go, clr, bq, dq, dir_seen, ovr_seen} = '0;
      {n_mismatch, cmp_count, cycles, per, pcnt, toggles} = '0;
      cfg      = '{1'b0, 1'b0, 1'b0, 1'b0, 8'h32};
      tx_word  = '0;
      frame    = '0;
      rx_ready = 1'b1;
      step(5);
      `CHK({tx_ready, rx_valid, rx_overrun, tx_busy}, 4'h8)
      `CHK({data_pair_out.oe, bit_clock_pair_out.oe, dir_pair_out.oe}, 3'h0)
      @(posedge mclk);
      #1 rst_n = 1'b1;
      $display("test reset done");
      for (int i = 0; i < 3; i++)
      begin
         got.delete();
         far(rows[i]);
         `CHK(got.size(), 3)
         if (got.size() == 3)
         begin
            `CHK(got[0], {1'b0, rows[i][7:0]})
            `CHK(got[1], {1'b0, rows[i][15:8]})
            `CHK(got[2], 9'h100)
         end
      end
      $display("test receive rows done");
      got.delete();
      rx_ready = 1'b0;
      far(16'hA55A);
      `CHK(ovr_seen, 1'b1)
      `CHK(rx_valid, 1'b1)
      rx_ready = 1'b1;
      step(5);
      `CHK(got.size(), 2)
      `CHK(got[0], 9'h05A)
      `CHK(got[1], 9'h0A5)
      $display("test stalled buffer done");
      for (int j = 0; j < 2; j++)
      begin
         cfg.half_div = 8'(hv[j]);
         clr = 1'b1;
         step(1);
         clr = 1'b0;
         send('{1'b1, 8'hFF});
         `CHK(i_far.nraw, 25)
         `CHK(i_far.raw[24:0], 25'b0111111011111011101111110)
         `CHK(per, 2 * hv[j])
      end
      $display("test sync send done");
      for (int k = 0; k < 2; k++)
      begin
         cfg      = '{1'b1, 1'b0, 1'b1, stx[k][16], 8'h32};
         // reset in mid-run clears frame state left by earlier tests
         rst_n    = 1'b0;
         step(1);
         rst_n    = 1'b1;
         toggles  = 0;
         dir_seen = 1'b0;
         got.delete();
         send('{1'b1, stx[k][15:8]});
         `CHK(toggles, int'(stx[k][7:0]))
         `CHK(dir_seen, stx[k][16])
         `CHK(got.size(), 2)
         `CHK({got[0], got[1]}, {1'b0, stx[k][15:8], 9'h100})
      end
      $display("test self-clocked send done");
      // slow rate: two cells fit the wait, a fast rate would give about nine
      cfg      = '{1'b1, 1'b1, 1'b0, 1'b1, 8'h32};
      toggles  = 0;
      dir_seen = 1'b0;
      tx_word  = '{1'b1, 8'h00};
      tx_valid = 1'b1;
      step(1);
      tx_valid = 1'b0;
      step(2400);
      `CHK(toggles, 2)
      `CHK(dir_seen, 1'b0)
      rst_n = 1'b0;
      step(1);
      rst_n = 1'b1;
      repeat (2)
      begin
         step(1);
         `CHK({tx_ready, tx_busy, data_pair_out.oe, rx_valid, dir_pair_out.oe}, 5'h10)
      end
      $display("test mid-frame reset done");
      end_sim();
   end
endmodule // slc_line_codec_test

bind slc_line_codec slc_line_codec_assertions i_chk (.mclk, .rst_n, .cfg, .tx_valid,
   .tx_ready, .tx_busy, .rx_valid, .rx_word, .rx_ready, .rx_overrun, .data_pair_out,
   .bit_clock_pair_out, .dir_pair_out);
